// ---- afo_pkg.sv ----
package afo_pkg;

  // ---------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;

  localparam logic [APB_AW-1:0] ADDR_CFG = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_CTL = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_STS = 8'h08;

  // Configuration word fields.
  localparam int unsigned CFG_TWOS_BIT = 4;
  localparam int unsigned CFG_STAMP_BIT = 3;

  // Control word fields.
  localparam int unsigned CTL_PAT_BIT  = 0;
  localparam int unsigned CTL_PDI_BIT  = 1;
  localparam int unsigned CTL_PDQ_BIT  = 2;

  // Status word fields.
  localparam int unsigned STS_BYP_BIT  = 0;
  localparam int unsigned STS_TRG_BIT  = 1;
  localparam int unsigned STS_FCLK_BIT = 2;
  localparam int unsigned STS_CNT_LSB  = 4;

  // ---------------------------------------------------------------
  // Sample format
  // ---------------------------------------------------------------
  localparam int unsigned SW = 12;
  localparam logic [SW-1:0] MSB_FLIP = 12'h800;
  localparam logic [SW-1:0] ZERO_W   = 12'h000;

  // ---------------------------------------------------------------
  // Test pattern, low words; the high words are their complements
  // ---------------------------------------------------------------
  localparam logic [SW-1:0] PAT_DQ = 12'h000;
  localparam logic [SW-1:0] PAT_DLY_I = 12'h004;
  localparam logic [SW-1:0] PAT_Q  = 12'h008;
  localparam logic [SW-1:0] PAT_I  = 12'h010;

  // Bit k set means word k of the sequence is high.
  localparam logic [9:0] DMX_SEQ = 10'h00A;
  localparam logic [9:0] BYP_SEQ = 10'h3AC;
  localparam logic [3:0] DMX_LEN = 4'h5;
  localparam logic [3:0] BYP_LEN = 4'hA;

endpackage : afo_pkg

// ---- afo_formatter.sv ----
`timescale 1ns/1ps
module afo_formatter
  import afo_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire logic              clk_link_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic [APB_DW-1:0] pwdata_i,
  output logic      [APB_DW-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              demux_bypass_pin_i,
  input  wire logic              output_clock_reset_input_i,
  input  wire logic [SW-1:0]     sample_q_i,
  input  wire logic [SW-1:0]     sample_i_i,
  input  wire logic              conv_or_q_i,
  input  wire logic              conv_or_i_i,
  output logic      [SW-1:0]     delayed_q_bus_o,
  output logic      [SW-1:0]     delayed_i_bus_o,
  output logic      [SW-1:0]     q_bus_o,
  output logic      [SW-1:0]     i_bus_o,
  output logic                   over_range_q_o,
  output logic                   over_range_i_o,
  output logic                   forwarded_output_clock_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic trg_l1;
    logic trg_l2;
  } afo_link_t;

  typedef struct packed {
    logic              cfg_twos;
    logic              cfg_stamp;
    logic              ctl_pat;
    logic              ctl_pdi;
    logic              ctl_pdq;
    logic              byp_s1;
    logic              byp_s2;
    logic              trg_s1;
    logic              trg_s2;
    logic              phase;
    logic [3:0]        pat_cnt;
    logic [SW-1:0]     hold_q;
    logic [SW-1:0]     hold_i;
    logic              hold_ovq;
    logic              hold_ovi;
    logic [SW-1:0]     out_dq;
    logic [SW-1:0]     out_dly_i;
    logic [SW-1:0]     out_q;
    logic [SW-1:0]     out_i;
    logic              out_ovq;
    logic              out_ovi;
    logic              fclk;
    logic [APB_DW-1:0] prdata;
  } afo_sys_t;

  afo_link_t lnk_reg;
  afo_link_t lnk_next;
  afo_sys_t  sys_reg;
  afo_sys_t  sys_next;
  logic      [SW-1:0] fmt_q;
  logic      [SW-1:0] fmt_i;
  logic      word;
  logic      pat_hi;
  logic      acc;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [SW-1:0] fmt_sample(input logic [SW-1:0] s,
                                                input logic twos,
                                                input logic stamp,
                                                input logic trg);
    logic [SW-1:0] v;
    v = twos ? (s ^ MSB_FLIP) : s;
    if (stamp) begin
      v[0] = trg;
    end
    return v;
  endfunction : fmt_sample

  // Pattern words are sent as they are or as their own complement.
  function automatic logic [SW-1:0] pat_sel(input logic [SW-1:0] w,
                                             input logic hi);
    return hi ? ~w : w;
  endfunction : pat_sel

  function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
    logic hit;
    if (a == ADDR_CFG) begin
      hit = 1'b1;
    end else if (a == ADDR_CTL) begin
      hit = 1'b1;
    end else if (a == ADDR_STS) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction : addr_mapped

  // ---------------------------------------------------------------
  // Link domain: trigger capture
  // ---------------------------------------------------------------
  // The trigger has no fixed phase to either clock, so it is first
  // settled on the link clock and then crossed again as a level.
  always_comb begin
    lnk_next        = lnk_reg;
    lnk_next.trg_l1 = output_clock_reset_input_i;
    lnk_next.trg_l2 = lnk_reg.trg_l1;
  end

  always_ff @(posedge clk_link_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lnk_reg <= '0;
    end else begin
      lnk_reg <= lnk_next;
    end
  end

  // ---------------------------------------------------------------
  // Sampling clock domain
  // ---------------------------------------------------------------
  assign fmt_q  = fmt_sample(sample_q_i, sys_reg.cfg_twos, sys_reg.cfg_stamp, sys_reg.trg_s2);
  assign fmt_i  = fmt_sample(sample_i_i, sys_reg.cfg_twos, sys_reg.cfg_stamp, sys_reg.trg_s2);
  assign word   = sys_reg.byp_s2 | sys_reg.phase;
  assign pat_hi = sys_reg.byp_s2 ? BYP_SEQ[sys_reg.pat_cnt] : DMX_SEQ[sys_reg.pat_cnt];
  assign acc    = psel_i & penable_i;

  always_comb begin
    sys_next        = sys_reg;
    sys_next.byp_s1 = demux_bypass_pin_i;
    sys_next.byp_s2 = sys_reg.byp_s1;
    sys_next.trg_s1 = lnk_reg.trg_l2;
    sys_next.trg_s2 = sys_reg.trg_s1;

    // Register writes; the demux choice has no bit here on purpose.
    if (acc && pwrite_i) begin
      if (paddr_i == ADDR_CFG) begin
        sys_next.cfg_twos = pwdata_i[CFG_TWOS_BIT];
        sys_next.cfg_stamp = pwdata_i[CFG_STAMP_BIT];
      end else if (paddr_i == ADDR_CTL) begin
        sys_next.ctl_pat  = pwdata_i[CTL_PAT_BIT];
        sys_next.ctl_pdi  = pwdata_i[CTL_PDI_BIT];
        sys_next.ctl_pdq  = pwdata_i[CTL_PDQ_BIT];
      end
    end

    // Read data is latched in the setup cycle so it leaves a flop.
    if (psel_i && !penable_i) begin
      sys_next.prdata = '0;
      if (paddr_i == ADDR_CFG) begin
        sys_next.prdata[CFG_TWOS_BIT] = sys_reg.cfg_twos;
        sys_next.prdata[CFG_STAMP_BIT] = sys_reg.cfg_stamp;
      end else if (paddr_i == ADDR_CTL) begin
        sys_next.prdata[CTL_PAT_BIT]  = sys_reg.ctl_pat;
        sys_next.prdata[CTL_PDI_BIT]  = sys_reg.ctl_pdi;
        sys_next.prdata[CTL_PDQ_BIT]  = sys_reg.ctl_pdq;
      end else if (paddr_i == ADDR_STS) begin
        sys_next.prdata[STS_BYP_BIT]  = sys_reg.byp_s2;
        sys_next.prdata[STS_TRG_BIT]  = sys_reg.trg_s2;
        sys_next.prdata[STS_FCLK_BIT] = sys_reg.fclk;
        sys_next.prdata[STS_CNT_LSB +: 4] = sys_reg.pat_cnt;
      end
    end

    // Demux takes two samples per word; the earlier one waits here.
    // Interleaved streams need no extra logic: each channel already
    // holds one edge, so the same 1:2 split yields the 1:4 order.
    sys_next.phase = sys_reg.byp_s2 ? 1'b0 : ~sys_reg.phase;
    if (!sys_reg.byp_s2 && !sys_reg.phase) begin
      sys_next.hold_q   = fmt_q;
      sys_next.hold_i   = fmt_i;
      sys_next.hold_ovq = conv_or_q_i;
      sys_next.hold_ovi = conv_or_i_i;
    end

    if (word) begin
      sys_next.fclk = ~sys_reg.fclk;
      if (sys_reg.pat_cnt >= (sys_reg.byp_s2 ? BYP_LEN : DMX_LEN) - 4'h1) begin
        sys_next.pat_cnt = 4'h0;
      end else begin
        sys_next.pat_cnt = sys_reg.pat_cnt + 4'h1;
      end

      if (sys_reg.ctl_pat) begin
        if (sys_reg.byp_s2) begin
          // Only the two undelayed buses run here, so they carry the first word pair.
          sys_next.out_dq    = ZERO_W;
          sys_next.out_dly_i = ZERO_W;
          sys_next.out_q     = pat_sel(PAT_DQ, pat_hi);
          sys_next.out_i     = pat_sel(PAT_DLY_I, pat_hi);
        end else begin
          sys_next.out_dq    = pat_sel(PAT_DQ, pat_hi);
          sys_next.out_dly_i = pat_sel(PAT_DLY_I, pat_hi);
          sys_next.out_q     = pat_sel(PAT_Q, pat_hi);
          sys_next.out_i     = pat_sel(PAT_I, pat_hi);
        end
        sys_next.out_ovq = pat_hi;
        sys_next.out_ovi = pat_hi;
      end else if (sys_reg.byp_s2) begin
        sys_next.out_dq    = ZERO_W;
        sys_next.out_dly_i = ZERO_W;
        sys_next.out_q     = fmt_q;
        sys_next.out_i     = fmt_i;
        sys_next.out_ovq   = conv_or_q_i;
        sys_next.out_ovi   = conv_or_i_i;
      end else begin
        sys_next.out_dq    = sys_reg.hold_q;
        sys_next.out_dly_i = sys_reg.hold_i;
        sys_next.out_q     = fmt_q;
        sys_next.out_i     = fmt_i;
        sys_next.out_ovq   = sys_reg.hold_ovq | conv_or_q_i;
        sys_next.out_ovi   = sys_reg.hold_ovi | conv_or_i_i;
      end

      // A powered-down channel stays silent, pattern or not.
      if (sys_reg.ctl_pdq) begin
        sys_next.out_dq  = ZERO_W;
        sys_next.out_q   = ZERO_W;
        sys_next.out_ovq = 1'b0;
      end
      if (sys_reg.ctl_pdi) begin
        sys_next.out_dly_i = ZERO_W;
        sys_next.out_i     = ZERO_W;
        sys_next.out_ovi   = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_reg <= '0;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata_o                 = sys_reg.prdata;
  assign pready_o                 = 1'b1;
  assign pslverr_o                = acc & ~addr_mapped(paddr_i);
  assign delayed_q_bus_o          = sys_reg.out_dq;
  assign delayed_i_bus_o          = sys_reg.out_dly_i;
  assign q_bus_o                  = sys_reg.out_q;
  assign i_bus_o                  = sys_reg.out_i;
  assign over_range_q_o           = sys_reg.out_ovq;
  assign over_range_i_o           = sys_reg.out_ovi;
  assign forwarded_output_clock_o = sys_reg.fclk;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  a_twos_msb_flip: assert property (
    sys_reg.cfg_twos && !sys_reg.cfg_stamp |-> fmt_q == (sample_q_i ^ MSB_FLIP))
    else $error("two's complement must flip only the MSB");

  a_offset_default: assert property (
    !sys_reg.cfg_twos && !sys_reg.cfg_stamp |-> fmt_i == sample_i_i)
    else $error("offset binary must pass samples unchanged");

  a_ts_lsb_trig: assert property (
    sys_reg.cfg_stamp |-> fmt_q[0] == sys_reg.trg_s2 && fmt_i[0] == sys_reg.trg_s2)
    else $error("time stamp bit missing from sample LSB");

  a_byp_full_rate: assert property (
    sys_reg.byp_s2 && !sys_reg.ctl_pat && !sys_reg.ctl_pdq
    |=> q_bus_o == $past(fmt_q) && delayed_q_bus_o == ZERO_W)
    else $error("bypass mode must emit each sample on the Q bus");

  a_dmx_half_rate: assert property (
    !sys_reg.byp_s2 && !sys_reg.phase |=> $stable(q_bus_o) && $stable(i_bus_o))
    else $error("demux buses changed between words");

  a_dmx_word_order: assert property (
    !sys_reg.byp_s2 && sys_reg.phase && $past(!sys_reg.byp_s2)
    && !sys_reg.ctl_pat && !sys_reg.ctl_pdi
    |=> delayed_i_bus_o == $past(fmt_i, 2) && i_bus_o == $past(fmt_i))
    else $error("demux word order broken");

  a_pat_pair_hi: assert property (
    sys_reg.ctl_pat && !sys_reg.ctl_pdq && word ##1 over_range_q_o
    |-> q_bus_o == ($past(sys_reg.byp_s2) ? ~PAT_DQ : ~PAT_Q))
    else $error("pattern high word wrong on Q bus");

  a_pat_byp_seq: assert property (
    sys_reg.byp_s2 && sys_reg.ctl_pat && !sys_reg.ctl_pdi && sys_reg.pat_cnt == 4'h0
    && $stable(sys_reg.byp_s2)
    |=> i_bus_o == PAT_DLY_I ##1 i_bus_o == PAT_DLY_I ##1 i_bus_o == ~PAT_DLY_I)
    else $error("bypass pattern sequence wrong");

  a_pd_silent_ch: assert property (
    sys_reg.ctl_pdi && word |=> i_bus_o == ZERO_W && delayed_i_bus_o == ZERO_W
    && !over_range_i_o)
    else $error("powered-down channel still driven");

  a_fclk_per_word: assert property (
    word |=> forwarded_output_clock_o != $past(forwarded_output_clock_o))
    else $error("forwarded clock missed a word edge");

  a_mode_pin_only: assert property (
    $past(nrst_i, 2) |-> sys_reg.byp_s2 == $past(demux_bypass_pin_i, 2))
    else $error("demux mode did not follow the bypass pin");

  a_pat_over_range: assert property (
    sys_reg.ctl_pat && !sys_reg.ctl_pdq && word |=> over_range_q_o == $past(pat_hi))
    else $error("pattern over-range flag wrong");

  c_pat_demux: cover property (!sys_reg.byp_s2 && sys_reg.ctl_pat && word);
  c_pat_bypass: cover property (sys_reg.byp_s2 && sys_reg.ctl_pat && word);
  c_ts_trigger: cover property (sys_reg.cfg_stamp && $rose(sys_reg.trg_s2));
  c_twos_data: cover property (sys_reg.cfg_twos && !sys_reg.ctl_pat && word);

endmodule : afo_formatter

// ---- afo_capture_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Capture side: counts words and launches the trigger
// ---------------------------------------------------------------
module afo_capture_model (
  input  wire logic clk_link_i,
  input  wire logic nrst_i,
  input  wire logic fwd_clk_i,
  input  wire logic trig_req_i,
  output logic      trig_o,
  output int        words_o
);
  // The trigger leaves on the link clock, so it has no phase tie to sampling.
  always_ff @(posedge clk_link_i or negedge nrst_i) begin
    if (!nrst_i) trig_o <= 1'b0;
    else trig_o <= trig_req_i;
  end
  // One word is taken on every edge of the forwarded clock.
  always @(fwd_clk_i or negedge nrst_i) begin
    if (!nrst_i) words_o <= 0;
    else words_o <= words_o + 1;
  end
endmodule : afo_capture_model

// ---- adc_output_formatter_bench.sv ----
`timescale 1ns/1ps
module adc_output_formatter_bench;
  import afo_pkg::*;
  logic clk_sys_i, nrst_i, clk_link_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [APB_AW-1:0] paddr_i;
  logic [APB_DW-1:0] pwdata_i, prdata_o, rd;
  logic [SW-1:0]     sq, si, dq_o, dly_i_o, q_o, i_o;
  logic [12:0]       h1q, h2q, h1i, h2i;
  logic ovq, ovi, or_q_o, or_i_o, fclk, fclk_d, upd, re, byp, trig_req, trg;
  logic twos, stamp, pdq, pdi, exp_trg, chk_on;
  integer seed;
  int err_total, total_checks, words;
  event upd_ev;
  // ---------------------------------------------------------------
  // Clocks, design and capture model
  // ---------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    clk_link_i = 1'b0;
    #17;
    forever #24 clk_link_i = ~clk_link_i;
  end
  afo_formatter dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_link_i(clk_link_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .demux_bypass_pin_i(byp), .output_clock_reset_input_i(trg), .sample_q_i(sq),
    .sample_i_i(si), .conv_or_q_i(ovq), .conv_or_i_i(ovi), .delayed_q_bus_o(dq_o),
    .delayed_i_bus_o(dly_i_o), .q_bus_o(q_o), .i_bus_o(i_o), .over_range_q_o(or_q_o),
    .over_range_i_o(or_i_o), .forwarded_output_clock_o(fclk));
  afo_capture_model far (.clk_link_i(clk_link_i), .nrst_i(nrst_i), .fwd_clk_i(fclk),
    .trig_req_i(trig_req), .trig_o(trg), .words_o(words));
  always @(posedge clk_sys_i) begin
    sq  <= 12'($random(seed));
    si  <= 12'($random(seed));
    ovq <= 1'($random(seed));
    ovi <= 1'($random(seed));
    h1q <= {ovq, sq};
    h2q <= h1q;
    h1i <= {ovi, si};
    h2i <= h1i;
  end
  // ---------------------------------------------------------------
  // Expectations and compares
  // ---------------------------------------------------------------
  function automatic logic [11:0] ex(logic [11:0] s);
    logic [11:0] w;
    w = s ^ (twos ? 12'h800 : 12'h000);
    if (stamp) w[0] = exp_trg;
    return w;
  endfunction : ex
  function automatic logic is_rot(logic [9:0] g, logic [9:0] s, int n);
    logic ok;
    logic hit;
    hit = 1'b0;
    for (int r = 0; r < n; r++) begin
      ok = 1'b1;
      for (int k = 0; k < n; k++) begin
        if (g[k] !== s[(k + r) % n]) ok = 1'b0;
      end
      if (ok) hit = 1'b1;
    end
    return hit;
  endfunction : is_rot
  task automatic chk(string nm, logic [12:0] e, logic [12:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  // Words are judged at the falling edge, once the launching edge has settled.
  always @(negedge clk_sys_i) begin
    upd = (fclk !== fclk_d);
    fclk_d = fclk;
    if (chk_on && upd && byp) begin
      chk("q", pdq ? 13'h0 : {h1q[12], ex(h1q[11:0])}, {or_q_o, q_o});
      chk("i", pdi ? 13'h0 : {h1i[12], ex(h1i[11:0])}, {or_i_o, i_o});
      chk("dly_byp", 13'h0, {1'b0, dq_o | dly_i_o});
    end
    if (chk_on && upd && !byp) begin
      chk("dq", pdq ? 13'h0 : {1'b0, ex(h2q[11:0])}, {1'b0, dq_o});
      chk("q", pdq ? 13'h0 : {h1q[12] | h2q[12], ex(h1q[11:0])}, {or_q_o, q_o});
      chk("dly_i", pdi ? 13'h0 : {1'b0, ex(h2i[11:0])}, {1'b0, dly_i_o});
      chk("i", pdi ? 13'h0 : {h1i[12] | h2i[12], ex(h1i[11:0])}, {or_i_o, i_o});
    end
    if (upd) ->upd_ev;
  end
  // ---------------------------------------------------------------
  // Bus cycles and scenario helpers
  // ---------------------------------------------------------------
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    // Only the watchdog ends a wait that never sees ready.
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    re = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb
  task automatic cfg(logic [7:0] a, logic [31:0] d);
    chk_on = 1'b0;
    apb(1'b1, a, d);
    repeat (4) @(posedge clk_sys_i);
    if (a == ADDR_CFG) begin
      twos = d[CFG_TWOS_BIT];
      stamp = d[CFG_STAMP_BIT];
    end else begin
      pdi = d[CTL_PDI_BIT];
      pdq = d[CTL_PDQ_BIT];
    end
  endtask : cfg
  task automatic rate(int n);
    int w0;
    w0 = words;
    repeat (20) @(posedge clk_sys_i);
    chk_reg("words", 32'(n), 32'(words - w0));
  endtask : rate
  task automatic pat_word(logic dmx, output logic hb);
    logic [11:0] lq, li, ld, le;
    @(upd_ev);
    hb = q_o[11];
    lq = dmx ? 12'h008 : 12'h000;
    li = dmx ? 12'h010 : 12'h004;
    ld = dmx ? {12{hb}} : 12'h000;
    le = dmx ? (12'h004 ^ {12{hb}}) : 12'h000;
    chk("pdq", {1'b0, ld}, {1'b0, dq_o});
    chk("pdi", pdi ? 13'h0 : {1'b0, le}, {1'b0, dly_i_o});
    chk("pq", {hb, lq ^ {12{hb}}}, {or_q_o, q_o});
    chk("pi", pdi ? 13'h0 : {hb, li ^ {12{hb}}}, {or_i_o, i_o});
  endtask : pat_word
  task automatic pat_run(logic dmx, int n, logic [9:0] s);
    logic [9:0] g;
    logic hb;
    g = 10'h000;
    for (int k = 0; k < n; k++) begin
      pat_word(dmx, hb);
      g[k] = hb;
    end
    chk("pat_seq", 13'h001, {12'h000, is_rot(g, s, n)});
  endtask : pat_run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #(5000 * 100);
    err_total++;
    wrap_up();
  end
  initial begin
    seed = 91626;
    {nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {sq, si, ovq, ovi, trig_req, twos, stamp, pdq, pdi, exp_trg, chk_on} = '0;
    byp = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    apb(1'b0, ADDR_CFG, 32'h0);
    chk_reg("cfg_reset", 32'h0, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk_reg("unmapped_err", 32'h1, {31'h0, re});
    apb(1'b1, ADDR_CFG, 32'h18);
    apb(1'b0, ADDR_CFG, 32'h0);
    chk_reg("cfg_rw", 32'h18, rd);
    apb(1'b1, ADDR_CTL, 32'h7);
    apb(1'b0, ADDR_CTL, 32'h0);
    chk_reg("ctl_rw", 32'h7, rd);
    apb(1'b1, ADDR_CTL, 32'h0);
    apb(1'b0, ADDR_STS, 32'h0);
    chk_reg("sts_pin", 32'h1, {31'h0, rd[STS_BYP_BIT]});
    $display("test registers done");
    cfg(ADDR_CFG, 32'h0);
    chk_on = 1'b1;
    rate(20);
    cfg(ADDR_CFG, 32'h10);
    chk_on = 1'b1;
    repeat (20) @(posedge clk_sys_i);
    $display("test bypass data done");
    byp <= 1'b0;
    // Every bit set except format and stamp: the mode must not move.
    cfg(ADDR_CFG, 32'hFFFFFFE7);
    chk_on = 1'b1;
    rate(10);
    cfg(ADDR_CTL, 32'h4);
    chk_on = 1'b1;
    repeat (20) @(posedge clk_sys_i);
    cfg(ADDR_CTL, 32'h0);
    cfg(ADDR_CFG, 32'h08);
    chk_on = 1'b1;
    repeat (20) @(posedge clk_sys_i);
    chk_on = 1'b0;
    trig_req <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    exp_trg = 1'b1;
    chk_on = 1'b1;
    repeat (20) @(posedge clk_sys_i);
    $display("test demux and stamp done");
    cfg(ADDR_CFG, 32'h0);
    cfg(ADDR_CTL, 32'h1);
    pat_run(1'b1, 5, 10'h00A);
    cfg(ADDR_CTL, 32'h3);
    pat_run(1'b1, 5, 10'h00A);
    cfg(ADDR_CTL, 32'h1);
    byp <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    pat_run(1'b0, 10, 10'h3AC);
    $display("test pattern done");
    wrap_up();
  end
endmodule : adc_output_formatter_bench
